/* File: hdl/noncoherent_semaphore_issue.sv */
// Summary of operation
// - load-and-clear word/double ignore the page uncacheable bit in all modes
// - force accel bit set: load-and-clear always moves line into data cache
// - force accel bit clear: hint chooses cache clear or controller clear
// - six noncoherent operators: clear, increment, decrement in word and double
// - noncoherent operators never cache the line; value returned as load data
// - controller returns old value then increments or decrements memory itself
// - noncoherent op on a line held in any processor cache returns an error
// - word ops accepted at any word, double ops at any double-word address
// - read of an armed fetch address returns the fetched value
// - armed ends cleared when the sequence is interrupted
// - second method: a plain load issues it, sized from the load size
// - coherent double increment done in every internode cache, weakly ordered
// - after that increment every processor holding the line invalidates it
// - uncached-fetch field at bits 54:55: off, increment, decrement, clear
// - first plain load of either size clears the field; only coherent reads translate and set 53
// - armed op access clears armed, sets 62; noncoherent ops issue if aligned (else error), coherent increment always issues; unarmed changes nothing
// - translation invalidate clears both bits when exactly one is set
module noncoherent_semaphore_issue (
   input wire logic clk,
   input wire logic rstn,
   // processor request
   input wire logic req_valid,
   input wire sem_pkg::acc_type req_kind,
   input wire logic req_double,
   input wire logic [63:0] req_wdata,
   input wire logic [39:0] req_addr,
   input wire logic req_coherent_space,
   input wire logic req_uncacheable,
   input wire logic req_load_clear,
   input wire logic req_cache_hint,
   output logic rsp_valid,
   output logic [63:0] rsp_rdata,
   output logic rsp_error,
   // interrupt and translation events
   input wire logic interrupt_abort,
   input wire logic tlb_invalidate,
   // diagnostic configuration
   input wire logic force_cache_accel_bit,
   // memory controller side
   output logic mem_valid,
   input wire logic mem_ready,
   output sem_pkg::mop_type mem_op,
   output logic [39:0] mem_addr,
   output logic mem_double,
   output logic [63:0] mem_wdata,
   output logic mem_to_cache,
   output logic mem_invalidate_all,
   input wire logic mem_done,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_line_cached,
   // register state visible to software
   output logic [63:0] op_context_reg,
   output logic [39:0] op_address_reg
);
   typedef enum logic [1:0] {IDLE, ISSUE, WAIT} state_type;

   state_type state_q, state_d;
   logic armed_q, armed_d;
   logic trig_q, trig_d;
   logic [1:0] ufetch_q, ufetch_d;
   logic ufetch_trig_q, ufetch_trig_d;
   logic [39:0] addr_q, addr_d;
   sem_pkg::mop_type op_q, op_d;
   logic [39:0] maddr_q, maddr_d;
   logic dbl_q, dbl_d;
   logic [63:0] mwdata_q, mwdata_d;
   logic to_cache_q, to_cache_d;
   logic rsp_valid_q, rsp_valid_d;
   logic [63:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic nc_q, nc_d;
   logic posted_q, posted_d;

   // operation addresses gated by the armed bit
   function automatic logic is_armed_op(input sem_pkg::acc_type k);
      return k inside {sem_pkg::ACC_FETCH_INC, sem_pkg::ACC_FETCH_DEC,
                       sem_pkg::ACC_FETCH_CLR, sem_pkg::ACC_NC_READ,
                       sem_pkg::ACC_NC_WRITE, sem_pkg::ACC_COH_INC};
   endfunction : is_armed_op

   // alignment check: word ops on 4 bytes, double ops on 8 bytes
   function automatic logic aligned(input logic [39:0] a, input logic d);
      return d ? (a[2:0] == 3'h0) : (a[1:0] == 2'h0);
   endfunction : aligned

   always_comb begin
      state_d = state_q;
      armed_d = armed_q;
      trig_d = trig_q;
      ufetch_d = ufetch_q;
      ufetch_trig_d = ufetch_trig_q;
      addr_d = addr_q;
      op_d = op_q;
      maddr_d = maddr_q;
      dbl_d = dbl_q;
      mwdata_d = mwdata_q;
      to_cache_d = to_cache_q;
      rsp_valid_d = 1'b0;
      rdata_d = rdata_q;
      err_d = 1'b0;
      nc_d = nc_q;
      posted_d = posted_q;
      // exactly one of armed/triggered set: both dropped
      if (tlb_invalidate && (armed_q ^ trig_q)) begin
         armed_d = 1'b0;
         trig_d = 1'b0;
      end
      // interrupted sequence never issues
      if (interrupt_abort) begin
         armed_d = 1'b0;
         trig_d = 1'b0;
      end
      case (state_q)
         IDLE: begin
            if (req_valid) begin
               maddr_d = addr_q;
               dbl_d = req_double;
               mwdata_d = req_wdata;
               to_cache_d = 1'b0;
               nc_d = 1'b0;
               posted_d = 1'b0;
               case (req_kind)
                  sem_pkg::ACC_CTX_WR: begin
                     trig_d = req_wdata[sem_pkg::TRIGGERED_BIT];
                     armed_d = req_wdata[sem_pkg::ARMED_BIT];
                     ufetch_trig_d = req_wdata[sem_pkg::UFETCH_TRIG_BIT];
                     // field bit 54 is the msb of the two-bit code
                     ufetch_d = {req_wdata[sem_pkg::UFETCH_ARM_LO],
                                 req_wdata[sem_pkg::UFETCH_ARM_HI]};
                     rsp_valid_d = 1'b1;
                  end
                  sem_pkg::ACC_ADDR_WR: begin
                     addr_d = req_wdata[39:0];
                     rsp_valid_d = 1'b1;
                  end
                  sem_pkg::ACC_CTX_RD, sem_pkg::ACC_ADDR_RD: begin
                     rdata_d = (req_kind == sem_pkg::ACC_CTX_RD) ? op_context_reg
                                                               : {24'h0, addr_q};
                     rsp_valid_d = 1'b1;
                  end
                  sem_pkg::ACC_MEM_LOAD: begin
                     maddr_d = req_addr;
                     op_d = sem_pkg::MOP_LOAD;
                     to_cache_d = !req_uncacheable;
                     if (req_load_clear) begin
                        // uncacheable bit deliberately not consulted
                        if (force_cache_accel_bit || req_cache_hint) begin
                           op_d = sem_pkg::MOP_LOAD_CLEAR_CACHE;
                           to_cache_d = 1'b1;
                        end else begin
                           op_d = sem_pkg::MOP_LOAD_CLEAR_MEM;
                           to_cache_d = 1'b0;
                        end
                     end else if (ufetch_q != sem_pkg::UFETCH_OFF) begin
                        ufetch_d = sem_pkg::UFETCH_OFF;
                        if (req_coherent_space) begin
                           ufetch_trig_d = 1'b1;
                           nc_d = 1'b1;
                           to_cache_d = 1'b0;
                           case (ufetch_q)
                              sem_pkg::UFETCH_INC: op_d = sem_pkg::MOP_FETCH_INC;
                              sem_pkg::UFETCH_DEC: op_d = sem_pkg::MOP_FETCH_DEC;
                              default: op_d = sem_pkg::MOP_FETCH_CLR;
                           endcase
                        end
                     end
                     state_d = ISSUE;
                  end
                  default: begin
                     if (is_armed_op(req_kind) && armed_q && !interrupt_abort) begin
                        armed_d = 1'b0;
                        trig_d = 1'b1;
                        nc_d = (req_kind != sem_pkg::ACC_COH_INC);
                        case (req_kind)
                           sem_pkg::ACC_FETCH_INC: op_d = sem_pkg::MOP_FETCH_INC;
                           sem_pkg::ACC_FETCH_DEC: op_d = sem_pkg::MOP_FETCH_DEC;
                           sem_pkg::ACC_FETCH_CLR: op_d = sem_pkg::MOP_FETCH_CLR;
                           sem_pkg::ACC_NC_READ: op_d = sem_pkg::MOP_NC_READ;
                           sem_pkg::ACC_NC_WRITE: op_d = sem_pkg::MOP_NC_WRITE;
                           default: begin
                              op_d = sem_pkg::MOP_COH_INC_DWORD;
                              addr_d = req_wdata[39:0];
                              maddr_d = req_wdata[39:0];
                              dbl_d = 1'b1;
                              posted_d = 1'b1;
                           end
                        endcase
                        state_d = ISSUE;
                     end else begin
                        // unarmed: undefined data, bits kept, write dropped
                        rdata_d = 64'h0;
                        rsp_valid_d = 1'b1;
                     end
                  end
               endcase
               if (nc_d && !aligned(maddr_d, dbl_d)) begin
                  // only natural alignment is guaranteed; reject the rest
                  state_d = IDLE;
                  err_d = 1'b1;
                  rsp_valid_d = 1'b1;
               end
            end
         end
         ISSUE: begin
            if (mem_ready) begin
               if (posted_q) begin
                  // weakly ordered: processor released at issue
                  rsp_valid_d = 1'b1;
                  state_d = IDLE;
               end else begin
                  state_d = WAIT;
               end
            end
         end
         WAIT: begin
            if (mem_done) begin
               rdata_d = mem_rdata;
               err_d = nc_q && mem_line_cached;
               rsp_valid_d = 1'b1;
               state_d = IDLE;
            end
         end
         default: state_d = IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= IDLE;
         armed_q <= sem_pkg::ARMED_RST;
         trig_q <= sem_pkg::TRIG_RST;
         ufetch_q <= sem_pkg::UFETCH_RST;
         ufetch_trig_q <= sem_pkg::TRIG_RST;
         addr_q <= sem_pkg::OP_ADDR_RST;
         op_q <= sem_pkg::MOP_NONE;
         maddr_q <= sem_pkg::OP_ADDR_RST;
         dbl_q <= 1'b0;
         mwdata_q <= 64'h0;
         to_cache_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rdata_q <= 64'h0;
         err_q <= 1'b0;
         nc_q <= 1'b0;
         posted_q <= 1'b0;
      end else begin
         state_q <= state_d;
         armed_q <= armed_d;
         trig_q <= trig_d;
         ufetch_q <= ufetch_d;
         ufetch_trig_q <= ufetch_trig_d;
         addr_q <= addr_d;
         op_q <= op_d;
         maddr_q <= maddr_d;
         dbl_q <= dbl_d;
         mwdata_q <= mwdata_d;
         to_cache_q <= to_cache_d;
         rsp_valid_q <= rsp_valid_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
         nc_q <= nc_d;
         posted_q <= posted_d;
      end
   end

   always_comb begin
      op_context_reg = 64'h0;
      op_context_reg[sem_pkg::ARMED_BIT] = armed_q;
      op_context_reg[sem_pkg::TRIGGERED_BIT] = trig_q;
      op_context_reg[sem_pkg::UFETCH_ARM_LO] = ufetch_q[1];
      op_context_reg[sem_pkg::UFETCH_ARM_HI] = ufetch_q[0];
      op_context_reg[sem_pkg::UFETCH_TRIG_BIT] = ufetch_trig_q;
   end

   assign op_address_reg = addr_q;
   assign mem_valid = (state_q == ISSUE);
   assign mem_op = op_q;
   assign mem_addr = maddr_q;
   assign mem_double = dbl_q;
   assign mem_wdata = mwdata_q;
   assign mem_to_cache = to_cache_q && !nc_q;
   // internode caches update in place, sharers drop their copies
   assign mem_invalidate_all = (state_q == ISSUE) && (op_q == sem_pkg::MOP_COH_INC_DWORD);
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rdata_q;
   assign rsp_error = err_q;
endmodule : noncoherent_semaphore_issue

/* File: hdl/sem_pkg.sv */
package sem_pkg;
   // operation context register bit positions
   localparam int TRIGGERED_BIT = 62;
   localparam int ARMED_BIT = 63;
   localparam int UFETCH_TRIG_BIT = 53;
   localparam int UFETCH_ARM_LO = 54;
   localparam int UFETCH_ARM_HI = 55;
   // uncached-fetch armed field codes
   localparam logic [1:0] UFETCH_OFF = 2'h0;
   localparam logic [1:0] UFETCH_INC = 2'h1;
   localparam logic [1:0] UFETCH_DEC = 2'h2;
   localparam logic [1:0] UFETCH_CLR = 2'h3;
   // reset values
   localparam logic ARMED_RST = 1'h0;
   localparam logic TRIG_RST = 1'h0;
   localparam logic [1:0] UFETCH_RST = 2'h0;
   localparam logic [39:0] OP_ADDR_RST = 40'h0;
   // processor-visible access kinds
   typedef enum logic [3:0] {
      ACC_NONE,
      ACC_CTX_WR,
      ACC_CTX_RD,
      ACC_ADDR_WR,
      ACC_ADDR_RD,
      ACC_FETCH_INC,
      ACC_FETCH_DEC,
      ACC_FETCH_CLR,
      ACC_NC_READ,
      ACC_NC_WRITE,
      ACC_COH_INC,
      ACC_MEM_LOAD
   } acc_type;
   // memory-side operations
   typedef enum logic [3:0] {
      MOP_NONE,
      MOP_LOAD,
      MOP_LOAD_CLEAR_CACHE,
      MOP_LOAD_CLEAR_MEM,
      MOP_FETCH_INC,
      MOP_FETCH_DEC,
      MOP_FETCH_CLR,
      MOP_NC_READ,
      MOP_NC_WRITE,
      MOP_COH_INC_DWORD
   } mop_type;
endpackage : sem_pkg

/* File: tb/sem_monitor.sv */
module sem_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire sem_pkg::acc_type req_kind,
   input wire logic req_double,
   input wire logic req_coherent_space,
   input wire logic req_load_clear,
   input wire logic req_cache_hint,
   input wire logic interrupt_abort,
   input wire logic tlb_invalidate,
   input wire logic force_cache_accel_bit,
   input wire logic mem_valid,
   input wire sem_pkg::mop_type mem_op,
   input wire logic mem_double,
   input wire logic [39:0] mem_addr,
   input wire logic mem_to_cache,
   input wire logic mem_invalidate_all,
   input wire logic mem_done,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_line_cached,
   input wire logic rsp_valid,
   input wire logic [63:0] rsp_rdata,
   input wire logic rsp_error,
   input wire logic [63:0] op_context_reg,
   input wire logic [39:0] op_address_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // increment code sits as bit 55 set, bit 54 clear
   sequence ufetch_load_s;
      req_valid && req_kind == sem_pkg::ACC_MEM_LOAD && req_coherent_space && !mem_valid
         && op_context_reg[55:54] == 2'h2;
   endsequence
   // armed noncoherent request, not interrupted, at a naturally aligned operation address
   sequence armed_fetch_s;
      req_valid && req_kind inside {sem_pkg::ACC_FETCH_INC, sem_pkg::ACC_FETCH_DEC,
         sem_pkg::ACC_FETCH_CLR, sem_pkg::ACC_NC_READ, sem_pkg::ACC_NC_WRITE}
         && op_context_reg[63] && !interrupt_abort && !mem_valid
         && (req_double ? op_address_reg[2:0] == 3'h0 : op_address_reg[1:0] == 2'h0);
   endsequence
   sequence good_done_s;
      mem_done && !mem_line_cached;
   endsequence
   unarmed_op_a: assert property (req_valid && req_kind == sem_pkg::ACC_FETCH_INC
      && !op_context_reg[63] && !mem_valid |=> rsp_valid && !mem_valid && rsp_rdata == 64'h0
      && op_context_reg[63:62] == $past(op_context_reg[63:62])) else $error("unarmed op acted");
   ufetch_issue_a: assert property (ufetch_load_s |=> mem_valid
      && mem_op == sem_pkg::MOP_FETCH_INC && mem_double == $past(req_double)
      && op_context_reg[55:53] == 3'h1) else $error("uncached fetch not translated");
   force_accel_a: assert property (req_valid && req_kind == sem_pkg::ACC_MEM_LOAD
      && req_load_clear && force_cache_accel_bit && !mem_valid |=> mem_valid
      && mem_op == sem_pkg::MOP_LOAD_CLEAR_CACHE && mem_to_cache) else $error("accel ignored");
   mem_clear_a: assert property (req_valid && req_kind == sem_pkg::ACC_MEM_LOAD
      && req_load_clear && !force_cache_accel_bit && !req_cache_hint && !mem_valid |=> mem_valid
      && mem_op == sem_pkg::MOP_LOAD_CLEAR_MEM && !mem_to_cache)
      else $error("controller clear misused");
   hint_cache_a: assert property (req_valid && req_kind == sem_pkg::ACC_MEM_LOAD
      && req_load_clear && !force_cache_accel_bit && req_cache_hint && !mem_valid |=> mem_valid
      && mem_op == sem_pkg::MOP_LOAD_CLEAR_CACHE && mem_to_cache)
      else $error("cache hint ignored");
   op_addr_a: assert property (armed_fetch_s |=> mem_valid
      && mem_addr == $past(op_address_reg) && mem_double == $past(req_double)
      && op_context_reg[63:62] == 2'h1) else $error("operation address not used");
   nc_uncached_a: assert property (mem_valid && mem_op inside {sem_pkg::MOP_FETCH_INC,
      sem_pkg::MOP_FETCH_DEC, sem_pkg::MOP_FETCH_CLR, sem_pkg::MOP_NC_READ,
      sem_pkg::MOP_NC_WRITE} |-> !mem_to_cache) else $error("noncoherent op cached");
   coh_inc_a: assert property (mem_valid && mem_op == sem_pkg::MOP_COH_INC_DWORD
      |-> mem_invalidate_all && mem_double) else $error("coherent increment malformed");
   cached_err_a: assert property (mem_done && mem_line_cached |=> rsp_valid && rsp_error)
      else $error("cached line gave no error");
   load_data_a: assert property (good_done_s |=> rsp_valid && !rsp_error
      && rsp_rdata == $past(mem_rdata)) else $error("fetched value lost");
   tlb_one_a: assert property (tlb_invalidate && !req_valid && !interrupt_abort
      && (op_context_reg[63] ^ op_context_reg[62]) |=> op_context_reg[63:62] == 2'h0)
      else $error("single bit kept on invalidate");
   tlb_both_a: assert property (tlb_invalidate && !req_valid && !interrupt_abort
      && op_context_reg[63:62] == 2'h3 |=> op_context_reg[63:62] == 2'h3)
      else $error("both bits lost on invalidate");
   abort_clear_a: assert property (interrupt_abort && !req_valid |=> !op_context_reg[63])
      else $error("armed survived interrupt");
endmodule : sem_monitor

bind noncoherent_semaphore_issue sem_monitor mon (.*);

/* File: tb/mem_ctrl_model.sv */
module mem_ctrl_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic mem_valid,
   input wire sem_pkg::mop_type mem_op,
   input wire logic [63:0] mem_wdata,
   input wire logic [1:0] lat,
   input wire logic cached,
   output logic mem_ready,
   output logic mem_done,
   output logic [63:0] mem_rdata,
   output logic mem_line_cached
);
   timeunit 1ns;
   timeprecision 1ns;
   // one variable stands for every line; address is not modelled
   logic [63:0] store_q, wd_q;
   logic [1:0] cnt_q;
   logic pend_q;
   sem_pkg::mop_type op_q;
   always_ff @(posedge clk) begin
      mem_ready <= 1'b0;
      mem_done <= 1'b0;
      mem_line_cached <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rstn) begin
         cnt_q <= 2'h0;
         pend_q <= 1'b0;
         store_q <= 64'h5;
      end else if (pend_q) begin
         mem_done <= 1'b1;
         mem_rdata <= store_q;
         mem_line_cached <= cached;
         pend_q <= 1'b0;
         if (!cached) begin
            case (op_q)
               sem_pkg::MOP_FETCH_INC: store_q <= store_q + 64'h1;
               sem_pkg::MOP_FETCH_DEC: store_q <= store_q - 64'h1;
               sem_pkg::MOP_FETCH_CLR, sem_pkg::MOP_LOAD_CLEAR_MEM: store_q <= 64'h0;
               sem_pkg::MOP_NC_WRITE: store_q <= wd_q;
               default: ;
            endcase
         end
      end else if (mem_valid && !mem_ready) begin
         if (cnt_q == lat) begin
            mem_ready <= 1'b1;
            cnt_q <= 2'h0;
            op_q <= mem_op;
            wd_q <= mem_wdata;
            // posted increment gets no completion
            pend_q <= mem_op != sem_pkg::MOP_COH_INC_DWORD;
            if (mem_op == sem_pkg::MOP_COH_INC_DWORD) store_q <= store_q + 64'h1;
         end else cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule : mem_ctrl_model

/* File: tb/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, req_valid, req_double, req_coherent_space, req_uncacheable;
   logic req_load_clear, req_cache_hint, rsp_valid, rsp_error, interrupt_abort, tlb_invalidate;
   logic force_cache_accel_bit, mem_valid, mem_ready, mem_double, mem_to_cache;
   logic mem_invalidate_all, mem_done, mem_line_cached, cached, er;
   logic [63:0] req_wdata, rsp_rdata, mem_wdata, mem_rdata, op_context_reg, rd, exp_v;
   logic [39:0] req_addr, mem_addr, op_address_reg;
   logic [1:0] lat;
   sem_pkg::acc_type req_kind;
   sem_pkg::mop_type mem_op;
   int failures, total_checks;
   sem_pkg::acc_type kinds [7] = '{sem_pkg::ACC_FETCH_INC, sem_pkg::ACC_FETCH_DEC,
      sem_pkg::ACC_FETCH_INC, sem_pkg::ACC_NC_WRITE, sem_pkg::ACC_NC_READ,
      sem_pkg::ACC_FETCH_CLR, sem_pkg::ACC_NC_READ};
   logic [63:0] ev_val [3] = '{64'h8000_0000_0000_0000, 64'hC000_0000_0000_0000,
      64'h8000_0000_0000_0000};
   logic [63:0] ev_exp [3] = '{64'h0, 64'h3, 64'h0};
   noncoherent_semaphore_issue uut (.*);
   mem_ctrl_model mcm (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic acc(input sem_pkg::acc_type k, input logic d, input logic [63:0] w);
      int n;
      @(posedge clk);
      #10;
      req_valid = 1'b1;
      req_kind = k;
      req_double = d;
      req_wdata = w;
      @(posedge clk);
      #10;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(posedge clk);
         #10;
         n++;
      end
      if (n == 40) begin
         failures++;
         $display("unexpected at %0t: no answer", $time);
         close_out();
      end else begin
         rd = rsp_rdata;
         er = rsp_error;
      end
   endtask : acc
   task automatic arm(input logic [39:0] a);
      acc(sem_pkg::ACC_CTX_WR, 1'b0, 64'h8000_0000_0000_0000);
      acc(sem_pkg::ACC_ADDR_WR, 1'b0, {24'h0, a});
   endtask : arm
   task automatic pulse(input logic t);
      @(posedge clk);
      #10;
      if (t) tlb_invalidate = 1'b1;
      else interrupt_abort = 1'b1;
      @(posedge clk);
      #10;
      tlb_invalidate = 1'b0;
      interrupt_abort = 1'b0;
   endtask : pulse
   initial begin
      {rstn, req_valid, req_double, req_coherent_space, req_uncacheable, req_load_clear} = 6'h0;
      {req_cache_hint, interrupt_abort, tlb_invalidate, force_cache_accel_bit, cached} = 5'h0;
      {req_wdata, req_addr, lat, failures, total_checks} = '0;
      req_kind = sem_pkg::ACC_NONE;
      repeat (5) @(posedge clk);
      #10;
      rstn = 1'b1;
      chk(op_context_reg, 64'h0);
      chk({24'h0, op_address_reg}, 64'h0);
      acc(sem_pkg::ACC_FETCH_INC, 1'b1, 64'h0);
      chk(rd, 64'h0);
      chk(op_context_reg, 64'h0);
      $display("test reset and unarmed done");
      exp_v = 64'h5;
      for (int i = 0; i < 7; i++) begin
         lat = 2'(i);
         arm(40'(40'h1000 + 4 * i));
         acc(kinds[i], ~1'(i), 64'h33);
         if (kinds[i] != sem_pkg::ACC_NC_WRITE) chk(rd, exp_v);
         chk({62'h0, op_context_reg[63:62]}, 64'h1);
         case (kinds[i])
            sem_pkg::ACC_FETCH_INC: exp_v = exp_v + 64'h1;
            sem_pkg::ACC_FETCH_DEC: exp_v = exp_v - 64'h1;
            sem_pkg::ACC_FETCH_CLR: exp_v = 64'h0;
            sem_pkg::ACC_NC_WRITE: exp_v = 64'h33;
            default: ;
         endcase
      end
      cached = 1'b1;
      arm(40'h1100);
      acc(sem_pkg::ACC_FETCH_CLR, 1'b0, 64'h0);
      chk({63'h0, er}, 64'h1);
      cached = 1'b0;
      arm(40'h1304);
      acc(sem_pkg::ACC_FETCH_INC, 1'b1, 64'h0);
      chk({63'h0, er}, 64'h1);
      $display("test first method done");
      acc(sem_pkg::ACC_CTX_WR, 1'b0, 64'h0080_0000_0000_0000);
      acc(sem_pkg::ACC_CTX_RD, 1'b1, 64'h0);
      chk(rd, 64'h0080_0000_0000_0000);
      req_coherent_space = 1'b1;
      acc(sem_pkg::ACC_MEM_LOAD, 1'b0, 64'h0);
      chk(rd, exp_v);
      chk({61'h0, op_context_reg[55:53]}, 64'h1);
      exp_v = exp_v + 64'h1;
      acc(sem_pkg::ACC_CTX_WR, 1'b0, 64'h0040_0000_0000_0000);
      req_coherent_space = 1'b0;
      acc(sem_pkg::ACC_MEM_LOAD, 1'b1, 64'h0);
      chk({61'h0, op_context_reg[55:53]}, 64'h0);
      $display("test second method done");
      {req_coherent_space, req_load_clear, req_uncacheable, force_cache_accel_bit} = 4'hF;
      acc(sem_pkg::ACC_MEM_LOAD, 1'b0, 64'h0);
      chk(rd, exp_v);
      force_cache_accel_bit = 1'b0;
      acc(sem_pkg::ACC_MEM_LOAD, 1'b1, 64'h0);
      chk(rd, exp_v);
      exp_v = 64'h0;
      req_cache_hint = 1'b1;
      acc(sem_pkg::ACC_MEM_LOAD, 1'b0, 64'h0);
      chk(rd, exp_v);
      req_cache_hint = 1'b0;
      req_load_clear = 1'b0;
      arm(40'h1200);
      acc(sem_pkg::ACC_NC_READ, 1'b1, 64'h0);
      chk(rd, exp_v);
      acc(sem_pkg::ACC_CTX_WR, 1'b0, 64'h8000_0000_0000_0000);
      acc(sem_pkg::ACC_COH_INC, 1'b1, 64'h2040);
      chk({24'h0, op_address_reg}, 64'h2040);
      arm(40'h2040);
      acc(sem_pkg::ACC_NC_READ, 1'b1, 64'h0);
      chk(rd, exp_v + 64'h1);
      $display("test load clear and increment done");
      for (int j = 0; j < 3; j++) begin
         acc(sem_pkg::ACC_CTX_WR, 1'b0, ev_val[j]);
         pulse(j < 2);
         acc(sem_pkg::ACC_CTX_RD, 1'b1, 64'h0);
         chk({62'h0, rd[63:62]}, ev_exp[j]);
      end
      $display("test invalidate and interrupt done");
      close_out();
   end
endmodule : tb
